// ### design/bsf_regs.vh
// Constants for the battery switch and fault control block
`ifndef BSF_REGS_VH
`define BSF_REGS_VH

// ----------------------------------------------------------------------
// Clock in megahertz and times in microseconds
// ----------------------------------------------------------------------
`define BSF_CLK_MHZ 40
`define BSF_DLY_SHORT_US 25000
`define BSF_DLY_LONG_US 12500000
`define BSF_PK_TIME_US 100
`define BSF_OCP_TIME_US 50000
`define BSF_HICCUP_OFF_US 100000
`define BSF_SHIP_EXIT_US 1000000
`define BSF_RESET_PRESS_US 10000000
`define BSF_RESET_OFF_US 100000
`define BSF_BATOVP_US 100

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define BSF_ADDR_CTRL 8'h00
`define BSF_ADDR_STATUS 8'h04
`define BSF_ADDR_FLAG 8'h08

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define BSF_F_SWCTRL 1:0
`define BSF_F_DLYSEL 2
`define BSF_F_AWARE 3
`define BSF_F_OTG 4
`define BSF_F_HIZ 5
`define BSF_F_PEAK 11:8

// ----------------------------------------------------------------------
// Switch control codes and reset values
// ----------------------------------------------------------------------
`define BSF_SW_NONE 2'h0
`define BSF_SW_SHUT 2'h1
`define BSF_SW_SHIP 2'h2
`define BSF_SW_RESET 2'h3
`define BSF_PEAK_DEFAULT 4'h8
`define BSF_SRC_NONE 3'h0

`endif

// ### design/bsf_sync.v
// Two-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
module bsf_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  input wire clk_in,
  input wire rst_b_in,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          stage1[i] <= INIT[i];
          stage2[i] <= INIT[i];
        end else begin
          stage1[i] <= async_in[i];
          stage2[i] <= stage1[i];
        end
      end
    end
  endgenerate
  assign sync_out = stage2;
endmodule // bsf_sync

// ### design/bsf_timer.v
// Run-while-high cycle counter with a level done output
`timescale 1ns/1ps
module bsf_timer (
  input wire clk_in,
  input wire rst_b_in,
  input wire run_in,
  input wire [31:0] limit_in,
  output wire done_out
);
  reg [31:0] count;
  // Holds at the limit so a long wait never wraps
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      count <= 32'h0;
    end else if (!run_in) begin
      count <= 32'h0;
    end else if (!done_out) begin
      count <= count + 32'h1;
    end
  end
  assign done_out = (count >= limit_in);
endmodule // bsf_timer

// ### design/bsf_switch_ctrl.v
// Battery switch mode sequencer and protection flags with APB registers
// Functional notes
// [RULE1] Code 01 opens switch, stops serial, shuts down
// [RULE2] Shutdown exits only on adapter, registers defaulted
// [RULE3] Switch-off waits 25 ms or 12.5 s
// [RULE4] Shutdown with adapter ignored, field back 00
// [RULE5] Shutdown during boost clears boost first
// [RULE6] Button ignored, pull-up off in shutdown
// [RULE7] Code 10 without adapter enters ship mode
// [RULE8] Ship exits on long press or adapter
// [RULE9] Aware 0: ship waits delay and removal
// [RULE10] Aware 1: switch off after delay, ship later
// [RULE11] Code 11 or long press power-cycles system
// [RULE12] Register reset delayed, button reset immediate
// [RULE13] System reset during boost clears boost first
// [RULE14] Battery undervoltage opens switch, stops serial
// [RULE15] Overcurrent sets fault, hiccups with 100 ms off
// [RULE16] Hiccup clears status, re-checks on turn-on
// [RULE17] Overcurrent during boost clears boost enable
// [RULE18] Input overvoltage stops switching, discharges, flags
// [RULE19] System overvoltage stops switching, pulls down, flags
// [RULE20] System short forces PFM and flags
// [RULE21] Battery overvoltage opens switch, discharges, flags
// [RULE22] Poor source stops switching, PG off, type 000
// [RULE23] Flags latch until read; status follows live
`timescale 1ns/1ps
`include "bsf_regs.vh"
module bsf_switch_ctrl #(
  parameter [31:0] DLY_SHORT_CYC = `BSF_DLY_SHORT_US * `BSF_CLK_MHZ,
  parameter [31:0] DLY_LONG_CYC = `BSF_DLY_LONG_US * `BSF_CLK_MHZ,
  parameter [31:0] OCP_SLOW_CYC = `BSF_OCP_TIME_US * `BSF_CLK_MHZ,
  parameter [31:0] HICCUP_OFF_CYC = `BSF_HICCUP_OFF_US * `BSF_CLK_MHZ,
  parameter [31:0] SHIP_EXIT_CYC = `BSF_SHIP_EXIT_US * `BSF_CLK_MHZ,
  parameter [31:0] RESET_PRESS_CYC = `BSF_RESET_PRESS_US * `BSF_CLK_MHZ,
  parameter [31:0] RESET_OFF_CYC = `BSF_RESET_OFF_US * `BSF_CLK_MHZ
) (
  input wire clk_in,
  input wire rst_b_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [7:0] paddr_in,
  input wire [31:0] pwdata_in,
  output reg [31:0] prdata_out,
  output reg pready_out,
  output reg pslverr_out,
  input wire adapter_present_in,
  input wire input_ov_in,
  input wire system_ov_in,
  input wire system_short_in,
  input wire battery_ov_in,
  input wire battery_uv_in,
  input wire poor_source_in,
  input wire sleep_in,
  input wire peak_over_in,
  input wire switch_ocp_in,
  input wire wake_button_n_in,
  input wire [2:0] detected_type_in,
  output reg battery_switch_on_out,
  output reg serial_enable_out,
  output reg wake_pullup_en_out,
  output reg reverse_boost_enable_out,
  output reg converter_run_out,
  output reg input_discharge_out,
  output reg sys_pulldown_out,
  output reg bat_discharge_out,
  output reg forced_pfm_out,
  output reg power_good_n_out,
  output reg input_high_impedance_out,
  output reg [3:0] discharge_peak_limit_out,
  output reg adapter_attach_out
);
  // --------------------------------------------------------------------
  // Modes and constants
  // --------------------------------------------------------------------
  localparam [2:0] M_NORMAL = 3'h0;
  localparam [2:0] M_WAIT = 3'h1;
  localparam [2:0] M_HOLD = 3'h2;
  localparam [2:0] M_SHIP = 3'h3;
  localparam [2:0] M_SHUT = 3'h4;
  localparam [2:0] M_RST = 3'h5;
  localparam [2:0] M_UVLO = 3'h6;
  localparam [31:0] PK_CYC = `BSF_PK_TIME_US * `BSF_CLK_MHZ;
  localparam [31:0] BOVP_CYC = `BSF_BATOVP_US * `BSF_CLK_MHZ;

  function hit;
    input [7:0] addr;
    input [7:0] offs;
    begin
      hit = (addr == offs);
    end
  endfunction

  // --------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------
  wire [10:0] sync_v;
  bsf_sync #(.WIDTH(11), .INIT(11'h400)) u_sync (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .async_in({wake_button_n_in, switch_ocp_in, peak_over_in, sleep_in, poor_source_in,
               battery_uv_in, battery_ov_in, system_short_in, system_ov_in, input_ov_in,
               adapter_present_in}),
    .sync_out(sync_v)
  );
  wire adapter = sync_v[0];
  wire in_ov = sync_v[1];
  wire sys_ov = sync_v[2];
  wire sys_short = sync_v[3];
  wire bat_ov = sync_v[4];
  wire bat_uv = sync_v[5];
  wire poor = sync_v[6];
  wire sleep = sync_v[7];
  wire pk_over = sync_v[8];
  wire ocp_over = sync_v[9];
  wire button_n = sync_v[10];

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  reg [2:0] mode;
  reg por_pend;
  reg [1:0] sw_ctrl;
  reg dly_sel;
  reg aware;
  reg otg;
  reg input_high_impedance;
  reg [3:0] peak;
  reg hiccup;
  reg ocp_stat;
  reg press_used;
  reg [3:0] flags;
  reg [3:0] stat_prev;
  reg attach_prev;

  wire [3:0] stat_now;
  wire bovp_stat;
  wire dly_done;
  wire pk_done;
  wire slow_done;
  wire hic_done;
  wire ship_press_done;
  wire rst_press_done;
  wire rst_off_done;
  wire bovp_done;

  // Serial access is refused while the switch logic is in a low-power mode
  wire acc_done = psel_in & penable_in & pready_out;
  wire wr_ctrl = acc_done & pwrite_in & serial_enable_out & hit(paddr_in, `BSF_ADDR_CTRL);
  wire rd_flag = acc_done & ~pwrite_in & serial_enable_out & hit(paddr_in, `BSF_ADDR_FLAG);
  wire [1:0] field_w = pwdata_in[`BSF_F_SWCTRL];
  wire aware_w = pwdata_in[`BSF_F_AWARE];
  wire pending = (mode == M_WAIT) | (mode == M_HOLD);
  wire ocp_trig = pk_done | slow_done;
  wire button_live = ~button_n & (mode != M_SHUT); // [RULE6]
  wire rst_press = rst_press_done & ~press_used;
  wire next_sw_on = ((mode == M_NORMAL) | (mode == M_WAIT) | ((mode == M_HOLD) & ~aware)) &
                    ~hiccup & ~bat_ov; // [RULE10] [RULE21]

  // --------------------------------------------------------------------
  // Timers
  // --------------------------------------------------------------------
  bsf_timer u_dly (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .run_in(pending),
    .limit_in(dly_sel ? DLY_LONG_CYC : DLY_SHORT_CYC), .done_out(dly_done) // [RULE3]
  );
  // Turn-off of the switch restarts both overcurrent timers
  bsf_timer u_pk (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .run_in(battery_switch_on_out & pk_over & ~hiccup),
    .limit_in(PK_CYC), .done_out(pk_done) // [RULE15] [RULE16]
  );
  bsf_timer u_slow (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .run_in(battery_switch_on_out & ocp_over & ~hiccup),
    .limit_in(OCP_SLOW_CYC), .done_out(slow_done) // [RULE15] [RULE16]
  );
  bsf_timer u_hic (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .run_in(hiccup),
    .limit_in(HICCUP_OFF_CYC), .done_out(hic_done)
  );
  bsf_timer u_ship_press (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .run_in(button_live),
    .limit_in(SHIP_EXIT_CYC), .done_out(ship_press_done)
  );
  bsf_timer u_rst_press (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .run_in(button_live),
    .limit_in(RESET_PRESS_CYC), .done_out(rst_press_done)
  );
  bsf_timer u_rst_off (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .run_in(mode == M_RST),
    .limit_in(RESET_OFF_CYC), .done_out(rst_off_done)
  );
  bsf_timer u_bovp (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .run_in(bat_ov),
    .limit_in(BOVP_CYC), .done_out(bovp_done)
  );

  // --------------------------------------------------------------------
  // Mode sequencer and control register
  // --------------------------------------------------------------------
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mode <= M_NORMAL;
      por_pend <= 1'b0;
      sw_ctrl <= `BSF_SW_NONE;
      dly_sel <= 1'b0;
      aware <= 1'b0;
      otg <= 1'b0;
      input_high_impedance <= 1'b0;
      peak <= `BSF_PEAK_DEFAULT;
      press_used <= 1'b0;
    end else if (por_pend) begin
      // Wake from a low-power mode reloads every default
      mode <= M_NORMAL; // [RULE2] [RULE8] [RULE14]
      por_pend <= 1'b0;
      sw_ctrl <= `BSF_SW_NONE;
      dly_sel <= 1'b0;
      aware <= 1'b0;
      otg <= 1'b0;
      input_high_impedance <= 1'b0;
      peak <= `BSF_PEAK_DEFAULT;
      press_used <= 1'b0;
    end else begin
      if (button_n) begin
        press_used <= 1'b0;
      end
      if (wr_ctrl) begin
        sw_ctrl <= field_w;
        dly_sel <= pwdata_in[`BSF_F_DLYSEL];
        aware <= aware_w;
        otg <= pwdata_in[`BSF_F_OTG];
        input_high_impedance <= pwdata_in[`BSF_F_HIZ];
        peak <= pwdata_in[`BSF_F_PEAK];
      end
      if (ocp_trig & otg) begin
        otg <= 1'b0; // [RULE17]
      end
      case (mode)
        M_NORMAL: begin
          if (wr_ctrl) begin
            case (field_w)
              `BSF_SW_SHUT: begin
                if (adapter) begin
                  sw_ctrl <= `BSF_SW_NONE; // [RULE4]
                end else begin
                  otg <= 1'b0; // [RULE5]
                  mode <= M_WAIT;
                end
              end
              `BSF_SW_SHIP: begin
                mode <= M_WAIT; // [RULE7]
              end
              `BSF_SW_RESET: begin
                if (aware_w | ~adapter) begin
                  otg <= 1'b0; // [RULE13]
                  mode <= M_WAIT; // [RULE11] [RULE12]
                end else begin
                  sw_ctrl <= `BSF_SW_NONE;
                end
              end
              default: begin
              end
            endcase
          end else if (rst_press & (aware | ~adapter)) begin
            otg <= 1'b0; // [RULE13]
            press_used <= 1'b1;
            mode <= M_RST; // [RULE11] [RULE12]
          end else if (~adapter & bat_uv) begin
            mode <= M_UVLO; // [RULE14]
          end
        end
        M_WAIT: begin
          if (wr_ctrl & (field_w == `BSF_SW_NONE)) begin
            mode <= M_NORMAL;
          end else if (dly_done) begin
            case (sw_ctrl)
              `BSF_SW_SHUT: begin
                if (adapter) begin
                  sw_ctrl <= `BSF_SW_NONE; // [RULE4]
                  mode <= M_NORMAL;
                end else begin
                  mode <= M_SHUT; // [RULE1]
                end
              end
              `BSF_SW_SHIP: begin
                mode <= adapter ? M_HOLD : M_SHIP; // [RULE9] [RULE10]
              end
              `BSF_SW_RESET: begin
                mode <= M_RST;
              end
              default: begin
                mode <= M_NORMAL;
              end
            endcase
          end
        end
        M_HOLD: begin
          if (wr_ctrl & (field_w == `BSF_SW_NONE)) begin
            mode <= M_NORMAL;
          end else if (~adapter) begin
            mode <= M_SHIP; // [RULE9] [RULE10]
          end
        end
        M_SHIP: begin
          if (adapter | ship_press_done) begin
            por_pend <= 1'b1; // [RULE8]
          end
        end
        M_SHUT: begin
          if (adapter) begin
            por_pend <= 1'b1; // [RULE2]
          end
        end
        M_RST: begin
          if (rst_off_done) begin
            sw_ctrl <= `BSF_SW_NONE;
            mode <= M_NORMAL;
          end
        end
        M_UVLO: begin
          if (~bat_uv | adapter) begin
            por_pend <= 1'b1; // [RULE14]
          end
        end
        default: begin
          mode <= M_NORMAL;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Protection state and flags
  // --------------------------------------------------------------------
  assign bovp_stat = bat_ov & bovp_done; // [RULE21]
  assign stat_now = {sys_short, sys_ov, in_ov, ocp_stat | bovp_stat};

  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      hiccup <= 1'b0;
      ocp_stat <= 1'b0;
      flags <= 4'h0;
      stat_prev <= 4'h0;
      attach_prev <= 1'b0;
    end else begin
      // Status is high for two cycles: the last cycle the switch is on and the first cycle it is off
      ocp_stat <= ocp_trig; // [RULE15] [RULE16]
      if (ocp_trig) begin
        hiccup <= 1'b1; // [RULE15]
      end else if (hic_done) begin
        hiccup <= 1'b0; // [RULE16]
      end
      stat_prev <= stat_now;
      attach_prev <= adapter & ~poor;
      // A new event beats a read that clears in the same cycle
      if (por_pend) begin
        flags <= 4'h0;
      end else begin
        flags <= (flags & {4{~rd_flag}}) | (stat_now & ~stat_prev); // [RULE23]
      end
    end
  end

  // --------------------------------------------------------------------
  // Registered outputs
  // --------------------------------------------------------------------
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      battery_switch_on_out <= 1'b1;
      serial_enable_out <= 1'b1;
      wake_pullup_en_out <= 1'b1;
      reverse_boost_enable_out <= 1'b0;
      converter_run_out <= 1'b0;
      input_discharge_out <= 1'b0;
      sys_pulldown_out <= 1'b0;
      bat_discharge_out <= 1'b0;
      forced_pfm_out <= 1'b0;
      power_good_n_out <= 1'b1;
      input_high_impedance_out <= 1'b0;
      discharge_peak_limit_out <= `BSF_PEAK_DEFAULT;
      adapter_attach_out <= 1'b0;
    end else begin
      battery_switch_on_out <= next_sw_on; // [RULE1] [RULE7] [RULE14] [RULE15]
      serial_enable_out <= ~((mode == M_SHIP) | (mode == M_SHUT) | (mode == M_UVLO) |
                             por_pend); // [RULE1] [RULE7] [RULE14]
      wake_pullup_en_out <= (mode != M_SHUT); // [RULE6]
      reverse_boost_enable_out <= otg;
      converter_run_out <= adapter & ~poor & ~sleep & ~in_ov & ~sys_ov &
                           ~input_high_impedance_out; // [RULE18] [RULE19] [RULE22]
      input_discharge_out <= in_ov; // [RULE18]
      sys_pulldown_out <= sys_ov; // [RULE19]
      bat_discharge_out <= bat_ov; // [RULE21]
      forced_pfm_out <= sys_short; // [RULE20]
      power_good_n_out <= ~(adapter & ~poor & ~sleep); // [RULE22]
      input_high_impedance_out <= input_high_impedance | ((mode == M_RST) & aware & adapter);
      discharge_peak_limit_out <= peak;
      adapter_attach_out <= adapter & ~poor & ~attach_prev; // [RULE22]
    end
  end

  // --------------------------------------------------------------------
  // APB slave, one wait state
  // --------------------------------------------------------------------
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0;
    end else if (psel_in & penable_in & ~pready_out) begin
      pready_out <= 1'b1;
      pslverr_out <= ~serial_enable_out;
      prdata_out <= 32'h0;
      if (serial_enable_out & ~pwrite_in) begin
        if (hit(paddr_in, `BSF_ADDR_CTRL)) begin
          prdata_out <= {20'h0, peak, 2'h0, input_high_impedance, otg, aware, dly_sel, sw_ctrl};
        end else if (hit(paddr_in, `BSF_ADDR_STATUS)) begin
          prdata_out <= {21'h0, mode, power_good_n_out,
                         (adapter & ~poor) ? detected_type_in : `BSF_SRC_NONE,
                         stat_now}; // [RULE22] [RULE23]
        end else if (hit(paddr_in, `BSF_ADDR_FLAG)) begin
          prdata_out <= {28'h0, flags};
        end else begin
          pslverr_out <= 1'b1;
        end
      end else if (serial_enable_out & ~hit(paddr_in, `BSF_ADDR_CTRL)) begin
        pslverr_out <= ~(hit(paddr_in, `BSF_ADDR_STATUS) | hit(paddr_in, `BSF_ADDR_FLAG));
      end
    end else begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
    end
  end
endmodule // bsf_switch_ctrl

// ### verification/bsf_checker.sv
// Assertions for the battery switch block
`timescale 1ns/1ps
module bsf_checker (
  input wire clk_in,
  input wire rst_b_in,
  input wire psel_in,
  input wire penable_in,
  input wire pready_out,
  input wire pslverr_out,
  input wire serial_enable_out,
  input wire input_ov_in,
  input wire input_discharge_out,
  input wire system_ov_in,
  input wire sys_pulldown_out,
  input wire converter_run_out,
  input wire system_short_in,
  input wire forced_pfm_out,
  input wire battery_ov_in,
  input wire bat_discharge_out,
  input wire battery_switch_on_out,
  input wire poor_source_in,
  input wire power_good_n_out,
  input wire wake_pullup_en_out,
  input wire adapter_attach_out
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);
  sequence s_setup;
    psel_in && !penable_in;
  endsequence
  sequence s_answer;
    !pready_out ##1 pready_out;
  endsequence
  property p_apb_wait;
    s_setup |=> s_answer;
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("bad wait");
  property p_ready_pulse;
    pready_out |=> !pready_out;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready long");
  property p_serial_off;
    pready_out && !serial_enable_out && !$past(serial_enable_out) |-> pslverr_out;
  endproperty
  a_serial_off: assert property (p_serial_off) else $error("no pslverr");
  property p_in_ov;
    input_ov_in[*4] |-> input_discharge_out && !converter_run_out;
  endproperty
  a_in_ov: assert property (p_in_ov) else $error("input ov");
  property p_in_ov_clear;
    (!input_ov_in)[*4] |-> !input_discharge_out;
  endproperty
  a_in_ov_clear: assert property (p_in_ov_clear) else $error("discharge");
  property p_sys_ov;
    system_ov_in[*4] |-> sys_pulldown_out && !converter_run_out;
  endproperty
  a_sys_ov: assert property (p_sys_ov) else $error("system ov");
  property p_short;
    system_short_in[*4] |-> forced_pfm_out;
  endproperty
  a_short: assert property (p_short) else $error("no pfm");
  property p_short_clear;
    $fell(system_short_in) ##3 !system_short_in |=> !forced_pfm_out;
  endproperty
  a_short_clear: assert property (p_short_clear) else $error("pfm stuck");
  property p_bat_ov;
    battery_ov_in[*4] |-> bat_discharge_out && !battery_switch_on_out;
  endproperty
  a_bat_ov: assert property (p_bat_ov) else $error("battery ov");
  property p_poor;
    poor_source_in[*4] |-> power_good_n_out && !converter_run_out;
  endproperty
  a_poor: assert property (p_poor) else $error("poor source");
  property p_pullup;
    !wake_pullup_en_out |-> !serial_enable_out && !battery_switch_on_out;
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up");
  property p_attach;
    adapter_attach_out |=> !adapter_attach_out;
  endproperty
  a_attach: assert property (p_attach) else $error("attach long");
endmodule // bsf_checker

bind bsf_switch_ctrl bsf_checker u_chk (.*);

// ### verification/bsf_host_model.sv
// APB host model
`timescale 1ns/1ps
module bsf_host_model (
  input wire logic clk_in,
  input wire logic pready_in,
  input wire logic pslverr_in,
  input wire logic [31:0] prdata_in,
  output logic psel_out,
  output logic penable_out,
  output logic pwrite_out,
  output logic [7:0] paddr_out,
  output logic [31:0] pwdata_out
);
  initial {psel_out, penable_out} = 2'b00;
  // ----------------------------------------------------------------
  // One transfer; the bench watchdog ends a hang
  // ----------------------------------------------------------------
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
    @(posedge clk_in);
    psel_out <= 1'b1;
    pwrite_out <= w;
    paddr_out <= a;
    pwdata_out <= d;
    @(posedge clk_in);
    penable_out <= 1'b1;
    do @(posedge clk_in); while (pready_in !== 1'b1);
    r = prdata_in;
    e = pslverr_in;
    psel_out <= 1'b0;
    penable_out <= 1'b0;
  endtask
endmodule // bsf_host_model

// ### verification/testbench.sv
// Bench for the battery switch block
`timescale 1ns/1ps
`include "bsf_regs.vh"
module testbench;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic adapter = 1'b0;
  logic [6:0] fault = 7'h0;
  logic poor = 1'b0;
  logic peak = 1'b0;
  logic button_n = 1'b1;
  wire psel, penable, pwrite, pready, pslverr, sw, ser, pull, boost, input_high_impedance, pg_n, run;
  wire [7:0] paddr;
  wire [31:0] pwdata, prdata;
  wire [3:0] pk;
  int bad_count = 0;
  int n_checks = 0;
  int n;
  logic [31:0] ctrl_m;
  logic [31:0] lfsr_s = 32'hD4D2CA8D;
  logic [31:0] rd;
  logic err;
  always #12.5 clk_in = ~clk_in;
  bsf_switch_ctrl #(.DLY_SHORT_CYC(32'h14), .DLY_LONG_CYC(32'h28), .OCP_SLOW_CYC(32'h1E),
    .HICCUP_OFF_CYC(32'h19), .SHIP_EXIT_CYC(32'h0F), .RESET_PRESS_CYC(32'h23),
    .RESET_OFF_CYC(32'h0A)) u_dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .adapter_present_in(adapter), .input_ov_in(fault[1]), .system_ov_in(fault[2]),
    .system_short_in(fault[3]), .battery_ov_in(fault[0]), .battery_uv_in(fault[4]),
    .poor_source_in(poor), .sleep_in(fault[5]), .peak_over_in(peak), .switch_ocp_in(fault[6]),
    .wake_button_n_in(button_n), .detected_type_in(fault[6:4]), .battery_switch_on_out(sw),
    .serial_enable_out(ser), .wake_pullup_en_out(pull), .reverse_boost_enable_out(boost),
    .converter_run_out(run), .input_discharge_out(), .sys_pulldown_out(),
    .bat_discharge_out(), .forced_pfm_out(), .power_good_n_out(pg_n),
    .input_high_impedance_out(input_high_impedance), .discharge_peak_limit_out(pk), .adapter_attach_out());
  bsf_host_model u_host (.clk_in(clk_in), .pready_in(pready), .pslverr_in(pslverr),
    .prdata_in(prdata), .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite),
    .paddr_out(paddr), .pwdata_out(pwdata));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
  endfunction
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task cyc(input int k);
    repeat (k) @(posedge clk_in);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, rd, err);
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m = 32'hFFFFFFFF,
              input logic e = 1'b0);
    u_host.xfer(1'b0, a, 32'h0, rd, err);
    check(rd & m, exp);
    check(32'(err), 32'(e));
  endtask
  task wait_for(input logic v, input logic which, input int lim);
    n = 0;
    while ((which ? ser : sw) !== v && n < lim) begin
      @(posedge clk_in);
      n++;
    end
    check(32'(n < lim), 32'h1);
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clk_in);
    bad_count++;
    end_of_test;
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    cyc(20);
    rst_b_in <= 1'b1;
    cyc(2);
    check(32'({sw, ser, pull, pg_n}), 32'hF);
    rd_chk(`BSF_ADDR_CTRL, 32'h800);
    rd_chk(8'h0C, 32'h0, 32'hFFFFFFFF, 1'b1);
    repeat (4) begin
      lfsr_s = lfsr(lfsr_s);
      ctrl_m = lfsr_s & 32'h0F3C;
      wr(`BSF_ADDR_CTRL, ctrl_m);
      rd_chk(`BSF_ADDR_CTRL, ctrl_m);
      check(32'({pk, input_high_impedance, boost}), 32'({ctrl_m[11:8], ctrl_m[5], ctrl_m[4]}));
    end
    wr(`BSF_ADDR_CTRL, 32'h800);
    for (int i = 0; i < 4; i++) begin
      fault <= 4'h1 << i;
      cyc(8);
      if (i == 0) check(32'(sw), 32'h0);
      rd_chk(`BSF_ADDR_STATUS, 32'(fault & 4'hE), 32'hF);
      fault <= 4'h0;
      cyc(8);
      rd_chk(`BSF_ADDR_STATUS, 32'h0, 32'hF);
      rd_chk(`BSF_ADDR_FLAG, 32'((4'h1 << i) & 4'hE), 32'hF);
      rd_chk(`BSF_ADDR_FLAG, 32'h0, 32'hF);
    end
    wr(`BSF_ADDR_CTRL, 32'h810);
    peak <= 1'b1;
    wait_for(1'b0, 1'b0, 4100);
    check(32'(n > 3995 && n < 4010), 32'h1);
    peak <= 1'b0;
    wait_for(1'b1, 1'b0, 60);
    check(32'(n >= 24 && n <= 27), 32'h1);
    check(32'(boost), 32'h0);
    rd_chk(`BSF_ADDR_STATUS, 32'h0, 32'h1);
    rd_chk(`BSF_ADDR_FLAG, 32'h1, 32'h1);
    adapter <= 1'b1;
    cyc(8);
    check(32'(run), 32'h1);
    wr(`BSF_ADDR_CTRL, 32'h801);
    rd_chk(`BSF_ADDR_CTRL, 32'h800);
    poor <= 1'b1;
    cyc(8);
    rd_chk(`BSF_ADDR_STATUS, 32'h80, 32'hF0);
    poor <= 1'b0;
    adapter <= 1'b0;
    cyc(8);
    wr(`BSF_ADDR_CTRL, 32'h802);
    wait_for(1'b0, 1'b0, 200);
    check(32'(n >= 17 && n <= 24), 32'h1);
    cyc(4);
    rd_chk(`BSF_ADDR_CTRL, 32'h0, 32'hFFFFFFFF, 1'b1);
    button_n <= 1'b0;
    wait_for(1'b1, 1'b1, 100);
    check(32'(n >= 14), 32'h1);
    button_n <= 1'b1;
    cyc(4);
    rd_chk(`BSF_ADDR_CTRL, 32'h800);
    wr(`BSF_ADDR_CTRL, 32'h811);
    cyc(3);
    check(32'({boost, sw}), 32'h1);
    wait_for(1'b0, 1'b0, 200);
    cyc(4);
    check(32'({ser, pull}), 32'h0);
    button_n <= 1'b0;
    cyc(60);
    check(32'(ser), 32'h0);
    button_n <= 1'b1;
    adapter <= 1'b1;
    wait_for(1'b1, 1'b1, 50);
    cyc(4);
    rd_chk(`BSF_ADDR_CTRL, 32'h800);
    adapter <= 1'b0;
    cyc(8);
    wr(`BSF_ADDR_CTRL, 32'h813);
    wait_for(1'b0, 1'b0, 200);
    check(32'(boost), 32'h0);
    wait_for(1'b1, 1'b0, 50);
    check(32'(n >= 9 && n <= 12), 32'h1);
    cyc(4);
    rd_chk(`BSF_ADDR_CTRL, 32'h800);
    button_n <= 1'b0;
    wait_for(1'b0, 1'b0, 100);
    check(32'(n >= 34 && n <= 40), 32'h1);
    button_n <= 1'b1;
    wait_for(1'b1, 1'b0, 50);
    end_of_test;
  end
endmodule // testbench
